// ---- rtl/ddrms_regs.vh ----
// Register offsets, field positions, reset values and timing counts
`ifndef DDRMS_REGS_VH
`define DDRMS_REGS_VH
`define DDRMS_MODE_STATUS_OFS  8'h58
`define DDRMS_CLKOFF_HI        31
`define DDRMS_CLKOFF_LO        26
`define DDRMS_INIT_BIT         25
`define DDRMS_MRW_BIT          23
`define DDRMS_RESUME_HI        22
`define DDRMS_RESUME_LO        21
`define DDRMS_BURST_BIT        20
`define DDRMS_REFOFF_BIT       19
`define DDRMS_INTERVAL_HI      17
`define DDRMS_INTERVAL_LO      16
`define DDRMS_NIBBLE_HI        7
`define DDRMS_NIBBLE_LO        0
`define DDRMS_CLKOFF_RST       6'h00
`define DDRMS_RESUME_RST       2'h0
`define DDRMS_CLK_MHZ          100
`define DDRMS_REF_NS_00        20480
`define DDRMS_REF_NS_01        15360
`define DDRMS_REF_NS_10        10240
`define DDRMS_REF_NS_11        7680
// Periods in clock cycles at 100 MHz, sized to the 16-bit refresh timer
`define DDRMS_REF_CYC_00       16'h0800
`define DDRMS_REF_CYC_01       16'h0600
`define DDRMS_REF_CYC_10       16'h0400
`define DDRMS_REF_CYC_11       16'h0300
`define DDRMS_INIT_CYC         16'h00C8
`define DDRMS_BURST_MAX        3'h4
`define DDRMS_SAME_RUN_MIN     4'h8
`endif

// ---- rtl/ddrms_top.v ----
// DDR mode and status control register with refresh and resume sequencing
// Functional notes
// R1: Clock-off bits tristate matching clock pair
// R2: Reset clears all clock-off bits
// R3: Software only silences pairs at empty slots
// R4: Init-start bit is set-only, launches init
// R5: Software programs timing before starting init
// R6: Software writes all fields before memory access
// R7: Mode-write bit cleared after write issued
// R8: Software sets CAS latency before mode write
// R9: Resume field resets 00; clock-enables low
// R10: Value 01 raises clock-enable, full init
// R11: Value 1X exits self-refresh, no init
// R12: Burst mode queues up to four refreshes
// R13: Queue refreshes only during same-device runs
// R14: Refresh-inhibit bit stops all refresh requests
// R15: Interval field selects refresh request period
// R16: Per-rank bit marks nibble-wide devices
// R17: Nibble ranks use mask pins as strobes
// R18: Mask pads use strobe drive when any nibble
// R19: CAS latency code 00=3,01=2,10=2.5 cycles
// R20: Writing zero to set-only bits does nothing
// R21: Mode write waits for init and idle banks
`timescale 1ns/1ps
`include "ddrms_regs.vh"
module ddrms_top
(
  input  wire        CLK_I,          // Memory system clock
  input  wire        SRST_I,         // Synchronous reset, active high
  input  wire [7:0]  CFG_ADDR_I,     // Configuration register byte offset
  input  wire        CFG_WR_I,       // Configuration write strobe
  input  wire        CFG_RD_I,       // Configuration read strobe
  input  wire [3:0]  CFG_BE_I,       // Byte enables for the write
  input  wire [31:0] CFG_WDATA_I,    // Write data
  input  wire [1:0]  CAS_LATENCY_SETTING_I, // Latency code from timing reg
  input  wire        BANKS_IDLE_I,   // All banks precharged and idle
  input  wire        SAME_DEVICE_I,  // Current operation hits same device
  input  wire        REFRESH_DONE_I, // Controller issued one refresh
  input  wire        MRW_DONE_I,     // Controller issued the mode write
  input  wire [7:0]  RANK_ACTIVE_I,  // One-hot rank of current access
  output reg  [31:0] CFG_RDATA_O,    // Read data
  output reg         CFG_RVALID_O,   // Read data valid pulse
  output reg  [5:0]  CLOCK_PAIR_OE_O, // Memory clock pair output enables
  output reg         CKE_O,          // Clock-enable pins level
  output reg         INIT_SEQ_O,     // Full power-on init in progress
  output reg         SELF_REF_EXIT_O, // Self-refresh exit pulse
  output reg         MRW_REQ_O,      // Mode register write request
  output reg  [1:0]  MRW_CAS_O,      // Latency code carried by mode write
  output reg         REFRESH_REQ_O,  // Refresh request level
  output reg  [2:0]  REFRESH_PEND_O, // Refreshes to issue now
  output reg         MASK_AS_STROBE_O, // Mask pins act as strobes now
  output reg         MASK_PAD_STROBE_DRV_O // Mask pads use strobe drive
);

  // State codes of the power-up sequencer
  localparam [1:0] ST_HOLD = 2'h0;   // Clock-enables held low
  localparam [1:0] ST_INIT = 2'h1;   // Running full initialization
  localparam [1:0] ST_RUN  = 2'h2;   // Memory usable

  // Register fields
  reg [5:0]  clock_pair_off_q;        // One bit per clock pair
  reg        init_start_q;            // Set-only initialization start
  reg        mode_write_q;            // Pending mode register write
  reg [1:0]  resume_sequence_control_q; // Resume control field
  reg        burst_q;                 // Burst refresh enable
  reg        refresh_off_q;           // Refresh inhibit, debug only
  reg [1:0]  interval_q;              // Refresh interval select
  reg [7:0]  nibble_devices_q;        // Per rank nibble-wide marks

  // Sequencer and refresh state
  reg [1:0]  state_q;                 // Power-up state
  reg [15:0] init_cnt_q;              // Initialization timer
  reg        init_done_q;             // Initialization finished
  reg [15:0] ref_cnt_q;               // Refresh period timer
  reg [2:0]  pend_q;                  // Refreshes accumulated
  reg [3:0]  run_q;                   // Length of same-device run
  reg [15:0] period;                  // Selected refresh period

  wire       hit = CFG_ADDR_I == `DDRMS_MODE_STATUS_OFS; // Address decode
  wire       wr  = CFG_WR_I & hit;
  wire [31:0] wd = CFG_WDATA_I;
  wire       tick = ref_cnt_q == 16'h0000; // One refresh period elapsed
  // Long same-device run lets burst mode hold refreshes back
  wire       hold = burst_q & (run_q >= `DDRMS_SAME_RUN_MIN); // R13
  wire [31:0] rd_word = {clock_pair_off_q, init_start_q, 1'b0,
                         mode_write_q, resume_sequence_control_q,
                         burst_q, refresh_off_q, 1'b0, interval_q,
                         8'h00, nibble_devices_q}; // R20

  // Period lookup; fixed at the 100 MHz column
  always @*
  begin
    case (interval_q) // R15
      2'h0:    period = `DDRMS_REF_CYC_00;
      2'h1:    period = `DDRMS_REF_CYC_01;
      2'h2:    period = `DDRMS_REF_CYC_10;
      default: period = `DDRMS_REF_CYC_11;
    endcase
  end

  // Register writes; each byte lane gated by its enable
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      clock_pair_off_q          <= `DDRMS_CLKOFF_RST; // R2
      init_start_q              <= 1'b0;
      mode_write_q              <= 1'b0;
      resume_sequence_control_q <= `DDRMS_RESUME_RST; // R9
      // Fields undefined at reset get zero for determinism
      burst_q                   <= 1'b0;
      refresh_off_q             <= 1'b0;
      interval_q                <= 2'h0;
      nibble_devices_q          <= 8'h00;
    end
    else
    begin
      if (wr && CFG_BE_I[3])
      begin
        clock_pair_off_q <= wd[`DDRMS_CLKOFF_HI:`DDRMS_CLKOFF_LO]; // R1
        // Only a one sets; nothing but reset clears
        if (wd[`DDRMS_INIT_BIT])
          init_start_q <= 1'b1; // R4
      end
      if (wr && CFG_BE_I[2])
      begin
        resume_sequence_control_q <=
          wd[`DDRMS_RESUME_HI:`DDRMS_RESUME_LO];
        burst_q       <= wd[`DDRMS_BURST_BIT]; // R12
        refresh_off_q <= wd[`DDRMS_REFOFF_BIT]; // R14
        interval_q    <= wd[`DDRMS_INTERVAL_HI:`DDRMS_INTERVAL_LO];
      end
      if (wr && CFG_BE_I[0])
        nibble_devices_q <= wd[`DDRMS_NIBBLE_HI:`DDRMS_NIBBLE_LO]; // R16
      // Set wins over the completion clear in the same cycle
      if (wr && CFG_BE_I[2] && wd[`DDRMS_MRW_BIT])
        mode_write_q <= 1'b1; // R20
      else if (MRW_DONE_I && MRW_REQ_O)
        mode_write_q <= 1'b0; // R7
    end
  end

  // Read return one cycle after the strobe
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      CFG_RDATA_O  <= 32'h0000_0000;
      CFG_RVALID_O <= 1'b0;
    end
    else
    begin
      CFG_RVALID_O <= CFG_RD_I;
      // Unmapped offsets read as zero
      CFG_RDATA_O  <= (CFG_RD_I && hit) ? rd_word : 32'h0000_0000;
    end
  end

  // Power-up sequencer driving the clock-enable pins
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      state_q         <= ST_HOLD;
      init_cnt_q      <= 16'h0000;
      init_done_q     <= 1'b0;
      CKE_O           <= 1'b0;
      INIT_SEQ_O      <= 1'b0;
      SELF_REF_EXIT_O <= 1'b0;
    end
    else
    begin
      SELF_REF_EXIT_O <= 1'b0;
      case (state_q)
        ST_HOLD:
        begin
          CKE_O <= 1'b0; // R9
          if (resume_sequence_control_q[1])
          begin
            // Contents preserved, so no re-initialization
            CKE_O           <= 1'b1; // R11
            SELF_REF_EXIT_O <= 1'b1;
            init_done_q     <= 1'b1;
            state_q         <= ST_RUN;
          end
          else if (resume_sequence_control_q == 2'h1 && init_start_q)
          begin
            CKE_O      <= 1'b1; // R10
            INIT_SEQ_O <= 1'b1;
            init_cnt_q <= `DDRMS_INIT_CYC;
            state_q    <= ST_INIT;
          end
        end
        ST_INIT:
        begin
          if (init_cnt_q == 16'h0000)
          begin
            INIT_SEQ_O  <= 1'b0;
            init_done_q <= 1'b1;
            state_q     <= ST_RUN;
          end
          else
            init_cnt_q <= init_cnt_q - 16'h0001;
        end
        ST_RUN:
        begin
          // Field returned to 00 drops the clock-enables again
          if (resume_sequence_control_q == 2'h0)
          begin
            CKE_O       <= 1'b0; // R9
            init_done_q <= 1'b0;
            state_q     <= ST_HOLD;
          end
        end
        default:
          state_q <= ST_HOLD;
      endcase
    end
  end

  // Mode write request, deferred until memory ready
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      MRW_REQ_O <= 1'b0;
      MRW_CAS_O <= 2'h0;
    end
    else
    begin
      MRW_REQ_O <= mode_write_q & init_done_q & BANKS_IDLE_I
                   & ~(MRW_DONE_I & MRW_REQ_O); // R21
      MRW_CAS_O <= CAS_LATENCY_SETTING_I; // R19
    end
  end

  // Refresh timer and accumulation queue
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      ref_cnt_q      <= 16'h0000;
      pend_q         <= 3'h0;
      run_q          <= 4'h0;
      REFRESH_REQ_O  <= 1'b0;
      REFRESH_PEND_O <= 3'h0;
    end
    else
    begin
      ref_cnt_q <= tick ? period - 16'h0001 : ref_cnt_q - 16'h0001;
      // Saturating run length of same-device operations
      if (!SAME_DEVICE_I)
        run_q <= 4'h0;
      else if (run_q != 4'hF)
        run_q <= run_q + 4'h1;
      if (refresh_off_q || !init_done_q)
        pend_q <= 3'h0; // R14
      else if (tick && pend_q < `DDRMS_BURST_MAX)
        pend_q <= pend_q + 3'h1 - {2'h0, REFRESH_DONE_I && pend_q != 3'h0};
      else if (REFRESH_DONE_I && pend_q != 3'h0)
        pend_q <= pend_q - 3'h1;
      // Queue held only during long runs, never beyond four
      REFRESH_REQ_O  <= ~refresh_off_q & (pend_q != 3'h0) &
                        (~hold | pend_q >= `DDRMS_BURST_MAX); // R12
      REFRESH_PEND_O <= pend_q;
    end
  end

  // Clock pair enables and mask pin roles
  always @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      CLOCK_PAIR_OE_O       <= 6'h3F;
      MASK_AS_STROBE_O      <= 1'b0;
      MASK_PAD_STROBE_DRV_O <= 1'b0;
    end
    else
    begin
      CLOCK_PAIR_OE_O       <= ~clock_pair_off_q; // R1
      MASK_AS_STROBE_O      <= |(RANK_ACTIVE_I & nibble_devices_q); // R17
      MASK_PAD_STROBE_DRV_O <= |nibble_devices_q; // R18
    end
  end

endmodule

// ---- bench/ddrms_sva.sv ----
// Concurrent checks on the DDR mode and status block ports
`timescale 1ns/1ps
module ddrms_sva
(
  input wire logic        CLK_I, SRST_I, CFG_WR_I, CFG_RD_I, BANKS_IDLE_I,
  input wire logic        MRW_DONE_I, CKE_O, INIT_SEQ_O, SELF_REF_EXIT_O,
  input wire logic        MRW_REQ_O, CFG_RVALID_O, REFRESH_REQ_O,
  input wire logic        MASK_AS_STROBE_O, MASK_PAD_STROBE_DRV_O,
  input wire logic [7:0]  CFG_ADDR_I,
  input wire logic [3:0]  CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I, CFG_RDATA_O,
  input wire logic [1:0]  CAS_LATENCY_SETTING_I, MRW_CAS_O,
  input wire logic [5:0]  CLOCK_PAIR_OE_O,
  input wire logic [2:0]  REFRESH_PEND_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic [8:0] init_cnt_q; // Cycles spent in the init sequence
  logic [5:0] oe_exp_q;   // Enables implied by the last clock-off write
  wire        wr = CFG_WR_I && CFG_ADDR_I == 8'h58; // Register write
  // Helper state; the enable copy lets a two-cycle lag still be judged
  always @(posedge CLK_I)
  begin
    init_cnt_q <= INIT_SEQ_O ? init_cnt_q + 9'h001 : 9'h000;
    if (SRST_I)
      oe_exp_q <= 6'h3F;
    else if (wr && CFG_BE_I[3])
      oe_exp_q <= ~CFG_WDATA_I[31:26];
  end
  AST_OE_FOLLOW: assert property (wr && CFG_BE_I[3] |-> ##2
    CLOCK_PAIR_OE_O == oe_exp_q) else $error("clock enable mismatch");
  AST_RST_OE: assert property (disable iff (1'b0) SRST_I |=>
    CLOCK_PAIR_OE_O == 6'h3F && !CKE_O) else $error("reset state wrong");
  AST_CKE_HOLD: assert property (wr && CFG_BE_I[2] &&
    CFG_WDATA_I[22:21] == 2'h0 |-> ##2 !CKE_O) else $error("cke not low");
  AST_INIT_CKE: assert property ($rose(INIT_SEQ_O) |-> CKE_O)
    else $error("init without cke");
  AST_INIT_LEN: assert property ($fell(INIT_SEQ_O) |->
    init_cnt_q inside {[200:201]}) else $error("init length wrong");
  AST_SRX: assert property (SELF_REF_EXIT_O |-> CKE_O && !INIT_SEQ_O
    ##1 !SELF_REF_EXIT_O) else $error("self refresh exit wrong");
  AST_MRW_CLR: assert property (MRW_REQ_O && MRW_DONE_I &&
    !(wr && CFG_BE_I[2] && CFG_WDATA_I[23]) |=> !MRW_REQ_O)
    else $error("mode write not cleared");
  AST_MRW_WAIT: assert property ($rose(MRW_REQ_O) |->
    $past(BANKS_IDLE_I) && !INIT_SEQ_O) else $error("mode write early");
  AST_MRW_CAS: assert property (MRW_REQ_O &&
    $stable(CAS_LATENCY_SETTING_I) |-> MRW_CAS_O == CAS_LATENCY_SETTING_I)
    else $error("latency code wrong");
  AST_PEND_MAX: assert property (REFRESH_PEND_O <= 3'h4)
    else $error("too many pending refreshes");
  AST_REF_OFF: assert property (wr && CFG_BE_I[2] && CFG_WDATA_I[19]
    |-> ##2 !REFRESH_REQ_O ##1 REFRESH_PEND_O == 3'h0)
    else $error("refresh not inhibited");
  AST_RD_UNMAP: assert property (CFG_RD_I && CFG_ADDR_I != 8'h58 |=>
    CFG_RVALID_O && CFG_RDATA_O == 32'h0) else $error("unmapped read");
  AST_MASK_DRV: assert property (MASK_AS_STROBE_O |->
    MASK_PAD_STROBE_DRV_O) else $error("mask pad drive wrong");
endmodule
bind ddrms_top ddrms_sva ddrms_sva_inst (.*);

// ---- bench/ddrms_mem_model.sv ----
// Controller-side stand-in that issues mode writes and refreshes
`timescale 1ns/1ps
module ddrms_mem_model #(parameter int DLY = 3)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic mrw_req_i,
  input  wire logic ref_req_i,
  output logic      mrw_done_o,
  output logic      ref_done_o,
  output logic      banks_idle_o
);
  logic [3:0] mc_q, rc_q; // Wait counters, so answers are never instant
  // Banks count as busy while a refresh is outstanding
  assign banks_idle_o = !ref_req_i;
  // One done pulse per request after DLY cycles of delay
  always @(posedge clk_i)
  begin
    mrw_done_o <= 1'b0;
    ref_done_o <= 1'b0;
    mc_q <= (rst_i || !mrw_req_i || mrw_done_o) ? 4'h0 : mc_q + 4'h1;
    rc_q <= (rst_i || !ref_req_i || ref_done_o) ? 4'h0 : rc_q + 4'h1;
    if (mc_q == DLY) mrw_done_o <= 1'b1;
    if (rc_q == DLY) ref_done_o <= 1'b1;
  end
endmodule

// ---- bench/ddrms_top_test.sv ----
// Self-checking testbench for the DDR mode and status block
`timescale 1ns/1ps
module ddrms_top_test;
  logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, same_i = 0, rq_q = 0;
  logic rv, cke, init, srx, mreq, rreq, mstr, mdrv, idle, mdone, rdone;
  logic [7:0]  addr_i = 8'h58;
  logic [3:0]  be_i = 4'hF;
  logic [31:0] wd_i = 32'h0, rd_q = 32'h0, rdata;
  logic [15:0] gap = 16'h0, per = 16'h0; // Cycles between refresh requests
  logic [5:0]  oe;
  logic [2:0]  pend;
  logic [1:0]  mcas;
  int miscompares = 0, total_checks = 0, n;
  localparam logic [31:0] WD [4] = '{32'hFC1F00FF, 32'hFFFFFFFF, 0, 32'h55};
  localparam logic [3:0]  BE [4] = '{4'hF, 4'h8, 4'hF, 4'h1};
  localparam logic [31:0] EX [4] =
    '{32'hFC1B00FF, 32'hFE1B00FF, 32'h02000000, 32'h02000055};
  localparam logic [15:0] PER [4] = '{16'd2048, 16'd1536, 16'd1024, 16'd768};
  always #5 clk_i = ~clk_i;
  // Capture read data and time the refresh requests
  always @(posedge clk_i)
  begin
    if (rv) rd_q <= rdata;
    rq_q <= rreq;
    gap <= (rreq && !rq_q) ? 16'h1 : gap + 16'h1;
    if (rreq && !rq_q) per <= gap;
  end
  ddrms_top ddrms_top_inst (.CLK_I(clk_i), .SRST_I(srst_i), .CFG_ADDR_I(addr_i),
    .CFG_WR_I(wr_i), .CFG_RD_I(rd_i), .CFG_BE_I(be_i), .CFG_WDATA_I(wd_i),
    .CAS_LATENCY_SETTING_I(2'h2), .BANKS_IDLE_I(idle), .SAME_DEVICE_I(same_i),
    .REFRESH_DONE_I(rdone), .MRW_DONE_I(mdone), .RANK_ACTIVE_I(8'h01),
    .CFG_RDATA_O(rdata), .CFG_RVALID_O(rv), .CLOCK_PAIR_OE_O(oe),
    .CKE_O(cke), .INIT_SEQ_O(init), .SELF_REF_EXIT_O(srx), .MRW_REQ_O(mreq),
    .MRW_CAS_O(mcas), .REFRESH_REQ_O(rreq), .REFRESH_PEND_O(pend),
    .MASK_AS_STROBE_O(mstr), .MASK_PAD_STROBE_DRV_O(mdrv));
  ddrms_mem_model ddrms_mem_model_inst (.clk_i(clk_i), .rst_i(srst_i),
    .mrw_req_i(mreq), .ref_req_i(rreq), .mrw_done_o(mdone),
    .ref_done_o(rdone), .banks_idle_o(idle));
  task automatic chk(input string nm, input logic [31:0] ex, got);
    total_checks++;
    if (got !== ex)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Bus cycles: strobe for one edge, then let outputs settle
  task automatic acc(input logic w, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_i);
    wd_i <= d;
    be_i <= b;
    wr_i <= w;
    rd_i <= !w;
    rd_q <= 'x;
    @(posedge clk_i);
    wr_i <= 0;
    rd_i <= 0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
    // A wait that runs out is a mismatch
    if (s !== v) chk("wait", {31'h0, v}, {31'h0, s});
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #500000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    srst_i <= 0;
    acc(0, 0, 0);
    chk("reset reg", 0, rd_q);
    chk("reset oe", 32'h3F, {26'h0, oe});
    for (int i = 0; i < 4; i++)
    begin
      acc(1, WD[i], BE[i]);
      acc(0, 0, 0);
      chk("reg", EX[i], rd_q);
      chk("oe", {26'h0, ~EX[i][31:26]}, {26'h0, oe});
      chk("cke", 0, {31'h0, cke});
      chk("mask drv", {31'h0, |EX[i][7:0]}, {31'h0, mdrv});
      chk("mask strobe", {31'h0, EX[i][0]}, {31'h0, mstr});
    end
    addr_i <= 8'h5C;
    acc(0, 0, 0);
    chk("unmapped", 0, rd_q);
    addr_i <= 8'h58;
    acc(1, 32'h02200000, 4'hF);
    chk("init", 1, {31'h0, init});
    wt(init, 0, 300);
    chk("cke up", 1, {31'h0, cke});
    acc(1, 32'h02A00000, 4'hF);
    wt(mreq, 0, 50);
    acc(0, 0, 0);
    chk("mode write bit", 32'h02200000, rd_q);
    for (int c = 0; c < 4; c++)
    begin
      acc(1, 32'h02200000 | (c << 16), 4'hF);
      // Let the request left from the last period end first
      wt(rreq, 0, 20);
      wt(rreq, 1, 2100);
      wt(rreq, 0, 20);
      wt(rreq, 1, 2100);
      chk("period", {16'h0, PER[c]}, {16'h0, per});
    end
    acc(1, 32'h022B0000, 4'hF);
    n = 0;
    repeat (900)
    begin
      @(posedge clk_i);
      if (rreq !== 1'b0) n++;
    end
    chk("inhibit", 0, n);
    same_i <= 1;
    acc(1, 32'h02330000, 4'hF);
    wt(rreq, 1, 4000);
    chk("burst", 4, {29'h0, pend});
    same_i <= 0;
    srst_i <= 1;
    repeat (8) @(posedge clk_i);
    srst_i <= 0;
    acc(1, 32'h00400000, 4'h4);
    chk("resume cke", 1, {31'h0, cke});
    chk("resume init", 0, {31'h0, init});
    // Pairs to empty slots are silenced again after resume
    acc(1, 32'hF0000000, 4'h8);
    chk("oe after resume", 32'h03, {26'h0, oe});
    end_sim;
  end
endmodule
